// >>> logic/dvbw_pkg.sv
// Constants, register map and types of the vertical blank window block.
// Assumes one pixel clock and a simple strobe register port.
// What this block does
// (RULE1) In raw mode blanking drops when line and pixel match the f1 end.
// (RULE2) In embedded-sync modes blanking drops on the same f1 end match.
// (RULE3) Blanking never feeds the V bit of the embedded timing codes.
// (RULE4) The f1 V bit comes only from its own f1 V-bit control register; the code takes it from bit 0 of the ADDR_VBIT register shared with f2.
// (RULE5) In raw mode blanking rises when line and pixel match the f2 start.
// (RULE6) In embedded-sync modes blanking rises on the same f2 start match.
// (RULE7) The f2 V bit comes only from its own f2 V-bit control register; the code takes it from bit 1 of the ADDR_VBIT register shared with f1.
// (RULE8) The f1 end register holds end line in 27-16, end pixel in 11-0.
// (RULE9) The f2 start register holds start line 27-16, start pixel 11-0.
// (RULE10) Bits 31-28 and 15-12 of both registers read zero, writes ignored.
// (RULE11) Blanking rises when line and pixel match the f1 start position.
// (RULE12) Blanking drops when line and pixel match the f2 end position.
// (RULE13) Matches are checked every clock, blanking holds between events.
package dvbw_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0]  ADDR_F1_END    = 4'h0;
  localparam logic [3:0]  ADDR_F2_START  = 4'h1;
  localparam logic [3:0]  ADDR_F1_START  = 4'h2;
  localparam logic [3:0]  ADDR_F2_END    = 4'h3;
  localparam logic [3:0]  ADDR_VBIT      = 4'h4;
  localparam logic [3:0]  ADDR_MODE      = 4'h5;
  localparam logic [3:0]  ADDR_STATUS    = 4'h6;
  localparam int          LINE_LSB       = 16;
  localparam int          PIXEL_LSB      = 0;
  localparam int          POS_W          = 12;
  localparam logic [11:0] POS_RESET      = 12'h000;
  localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    DVBW_RAW = 3'b001,
    DVBW_BT656 = 3'b010,
    DVBW_YC = 3'b100
  } dvbw_mode_e;

  typedef struct packed {
    logic [11:0] line;
    logic [11:0] pixel;
  } dvbw_pos_s;

  // Packs a position into a register word, reserved bits zero
  function automatic logic [31:0] packPos(input dvbw_pos_s p);
    packPos = {4'h0, p.line, 4'h0, p.pixel};
  endfunction

  // Unpacks a written word, dropping reserved bits
  function automatic dvbw_pos_s unpackPos(input logic [31:0] w);
    unpackPos.line  = w[LINE_LSB +: POS_W];
    unpackPos.pixel = w[PIXEL_LSB +: POS_W];
  endfunction
endpackage

// >>> logic/dvbw_pos_if.sv
// Interface carrying the four blanking positions to the comparator.
// Assumes both ends run on the pixel clock.
`timescale 1ns/1ps
interface dvbw_pos_if;
  import dvbw_pkg::*;
  dvbw_pos_s f1Start;
  dvbw_pos_s f1End;
  dvbw_pos_s f2Start;
  dvbw_pos_s f2End;
  modport regs (output f1Start, f1End, f2Start, f2End);
  modport cmp  (input  f1Start, f1End, f2Start, f2End);
endinterface

// >>> logic/dvbw_top.sv
// Top of the vertical blank window block with its register port.
// Assumes a single-cycle strobe master on the pixel clock.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module dvbw_top
  import dvbw_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdata,
  // Frame counters
  input  wire logic [11:0] frameLineCounter,
  input  wire logic [11:0] framePixelCounter,
  // Display outputs
  output logic             verticalBlankOut,
  output logic [2:0]       videoMode,
  output logic             f1VbitOut,
  output logic             f2VbitOut
);
  import dvbw_pkg::*;

  typedef struct packed {
    dvbw_pos_s  f1Start;
    dvbw_pos_s  f1End;
    dvbw_pos_s  f2Start;
    dvbw_pos_s  f2End;
    logic       f1Vbit;
    logic       f2Vbit;
    dvbw_mode_e mode;
    logic [31:0] rdata;
  } dvbw_regs_s;

  dvbw_regs_s st_r;
  dvbw_regs_s st_nxt;
  dvbw_pos_if posBus ();

  // ==========================================================
  // Register writes and reads
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = '0;
    if (regWrite) begin
      unique case (regAddr)
        ADDR_F1_END:   st_nxt.f1End   = unpackPos(regWdata); // [RULE8] [RULE10]
        ADDR_F2_START: st_nxt.f2Start = unpackPos(regWdata); // [RULE9] [RULE10]
        ADDR_F1_START: st_nxt.f1Start = unpackPos(regWdata);
        ADDR_F2_END:   st_nxt.f2End   = unpackPos(regWdata);
        ADDR_VBIT: begin
          // V bits live apart from blanking positions
          st_nxt.f1Vbit = regWdata[0]; // [RULE4]
          st_nxt.f2Vbit = regWdata[1]; // [RULE7]
        end
        ADDR_MODE: begin
          if (regWdata[2:0] == DVBW_BT656 || regWdata[2:0] == DVBW_YC) begin
            st_nxt.mode = dvbw_mode_e'(regWdata[2:0]);
          end else begin
            st_nxt.mode = DVBW_RAW;
          end
        end
        default: ;
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        ADDR_F1_END:   st_nxt.rdata = packPos(st_r.f1End); // [RULE10]
        ADDR_F2_START: st_nxt.rdata = packPos(st_r.f2Start); // [RULE10]
        ADDR_F1_START: st_nxt.rdata = packPos(st_r.f1Start);
        ADDR_F2_END:   st_nxt.rdata = packPos(st_r.f2End);
        ADDR_VBIT:     st_nxt.rdata = {30'h0, st_r.f2Vbit, st_r.f1Vbit};
        ADDR_MODE:     st_nxt.rdata = {29'h0, st_r.mode};
        ADDR_STATUS:   st_nxt.rdata = {31'h0, verticalBlankOut};
        default:       st_nxt.rdata = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r <= '{f1Start: '0, f1End: '0, f2Start: '0, f2End: '0,
                f1Vbit: 1'b0, f2Vbit: 1'b0, mode: DVBW_RAW,
                rdata: 32'h0000_0000};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign posBus.f1Start = st_r.f1Start;
  assign posBus.f1End   = st_r.f1End;
  assign posBus.f2Start = st_r.f2Start;
  assign posBus.f2End   = st_r.f2End;
  assign regRdata  = st_r.rdata;
  assign videoMode = st_r.mode;
  // Mode does not gate blanking; it only drives videoMode and the ADDR_MODE readback
  assign f1VbitOut = st_r.f1Vbit; // [RULE3] [RULE4]
  assign f2VbitOut = st_r.f2Vbit; // [RULE3] [RULE7]

  // ==========================================================
  // Blanking generator
  dvbw_vblank_gen uGen (
    .clock             (clock),
    .nrst              (nrst),
    .pos               (posBus),
    .frameLineCounter  (frameLineCounter),
    .framePixelCounter (framePixelCounter),
    .verticalBlankOut  (verticalBlankOut)
  );

  // ==========================================================
  // Checks
  property p_f1end_rd;
    @(posedge clock) disable iff (!nrst)
      (regRead && regAddr == ADDR_F1_END) |=>
        (regRdata[31:28] == 4'h0 && regRdata[15:12] == 4'h0 &&
         regRdata[27:16] == st_r.f1End.line &&
         regRdata[11:0] == st_r.f1End.pixel);
  endproperty
  a_f1end_rd: assert property (p_f1end_rd) else $error("f1 end read bad"); // [RULE8]

  property p_f2st_wr;
    @(posedge clock) disable iff (!nrst)
      (regWrite && regAddr == ADDR_F2_START) |=>
        (st_r.f2Start.line == $past(regWdata[27:16]) &&
         st_r.f2Start.pixel == $past(regWdata[11:0]));
  endproperty
  a_f2st_wr: assert property (p_f2st_wr) else $error("f2 start write bad"); // [RULE9]

  property p_resv;
    @(posedge clock) disable iff (!nrst)
      $past(regRead) && ($past(regAddr) == ADDR_F2_START) |->
        (regRdata[31:28] == 4'h0 && regRdata[15:12] == 4'h0);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits nonzero"); // [RULE10]

  property p_vbit;
    @(posedge clock) disable iff (!nrst)
      !(regWrite && regAddr == ADDR_VBIT) |=> $stable(f1VbitOut);
  endproperty
  a_vbit: assert property (p_vbit) else $error("f1 vbit moved"); // [RULE4]

  property p_vbit2;
    @(posedge clock) disable iff (!nrst)
      !(regWrite && regAddr == ADDR_VBIT) |=> $stable(f2VbitOut);
  endproperty
  a_vbit2: assert property (p_vbit2) else $error("f2 vbit moved"); // [RULE7]

  c_wr: cover property (@(posedge clock) disable iff (!nrst)
    regWrite && regAddr == ADDR_F1_END);
  c_emb: cover property (@(posedge clock) disable iff (!nrst)
    videoMode == DVBW_BT656 && verticalBlankOut);
endmodule

// >>> logic/dvbw_vblank_gen.sv
// Blanking level generator driven by frame counter matches.
// Assumes counters are synchronous to clock.
`timescale 1ns/1ps
module dvbw_vblank_gen
  import dvbw_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Positions and counters
  dvbw_pos_if.cmp         pos,
  input  wire logic [11:0] frameLineCounter,
  input  wire logic [11:0] framePixelCounter,
  // Output
  output logic            verticalBlankOut
);
  import dvbw_pkg::*;

  typedef struct packed {
    logic blank;
  } dvbw_gen_s;

  dvbw_gen_s st_r;
  dvbw_gen_s st_nxt;
  dvbw_pos_s here;
  logic      setHit;
  logic      clrHit;

  function automatic logic hit(input dvbw_pos_s a, input dvbw_pos_s b);
    hit = (a.line == b.line) && (a.pixel == b.pixel);
  endfunction

  // ==========================================================
  // Match logic, same in every mode
  always_comb begin
    here.line  = frameLineCounter;
    here.pixel = framePixelCounter;
    setHit = hit(here, pos.f1Start) || hit(here, pos.f2Start); // [RULE5] [RULE6] [RULE11]
    clrHit = hit(here, pos.f1End) || hit(here, pos.f2End); // [RULE1] [RULE2] [RULE12]
    st_nxt = st_r;
    // Set beats clear if positions coincide, so blanking is never lost
    if (setHit) begin
      st_nxt.blank = 1'b1;
    end else if (clrHit) begin
      st_nxt.blank = 1'b0;
    end // [RULE13]
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign verticalBlankOut = st_r.blank;

  // ==========================================================
  // Checks
  property p_rise;
    @(posedge clock) disable iff (!nrst)
      setHit |=> verticalBlankOut;
  endproperty
  a_rise: assert property (p_rise) else $error("blank did not rise"); // [RULE5]

  property p_fall;
    @(posedge clock) disable iff (!nrst)
      (clrHit && !setHit) |=> !verticalBlankOut;
  endproperty
  a_fall: assert property (p_fall) else $error("blank did not drop"); // [RULE1]

  property p_hold;
    @(posedge clock) disable iff (!nrst)
      (!setHit && !clrHit) |=> $stable(verticalBlankOut);
  endproperty
  a_hold: assert property (p_hold) else $error("blank moved alone"); // [RULE13]

  property p_f2end;
    @(posedge clock) disable iff (!nrst)
      (hit(here, pos.f2End) && !setHit) ##1 1'b1 |-> !verticalBlankOut;
  endproperty
  a_f2end: assert property (p_f2end) else $error("f2 end missed"); // [RULE12]

  c_rise: cover property (@(posedge clock) disable iff (!nrst)
    $rose(verticalBlankOut));
  c_fall: cover property (@(posedge clock) disable iff (!nrst)
    $fell(verticalBlankOut));
  c_both: cover property (@(posedge clock) disable iff (!nrst)
    setHit && clrHit);
endmodule

// >>> testbench/dvbw_display_model.sv
// Display receiver model that counts blanking intervals it is sent.
// Assumes blanking is a registered level on the pixel clock.
`timescale 1ns/1ps
module dvbw_display_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Blanking from the block
  input  wire logic       verticalBlankIn,
  // Observation
  output logic [7:0]      riseCount
);
  logic blankPrev;

  // ==========================================================
  // Edge counter
  // Counts rises only, so a held level never counts twice
  always_ff @(posedge clock) begin
    if (!nrst) begin
      blankPrev <= 1'b0;
      riseCount <= 8'h00;
    end else begin
      blankPrev <= verticalBlankIn;
      if (verticalBlankIn && !blankPrev) begin
        riseCount <= riseCount + 8'h01;
      end
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the vertical blank window block.
// Assumes the design files and the display model are compiled first.
`timescale 1ns/1ps
module tb_top;
  import dvbw_pkg::*;
  logic        clock;
  logic        nrst;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic [11:0] lineCnt;
  logic [11:0] pixCnt;
  logic        vblank;
  logic [2:0]  videoMode;
  logic        f1Vbit;
  logic        f2Vbit;
  logic [7:0]  riseCount;
  int          mismatches;
  int          checks_done;
  dvbw_mode_e  modes [3] = '{DVBW_RAW, DVBW_BT656, DVBW_YC};

  // ==========================================================
  // Instances
  dvbw_top dvbw_top_inst (
    .clock(clock), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .frameLineCounter(lineCnt),
    .framePixelCounter(pixCnt), .verticalBlankOut(vblank),
    .videoMode(videoMode), .f1VbitOut(f1Vbit), .f2VbitOut(f2Vbit)
  );
  dvbw_display_model dvbw_display_model_inst (
    .clock(clock), .nrst(nrst), .verticalBlankIn(vblank),
    .riseCount(riseCount)
  );

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic regRd(input logic [3:0] a, input logic [31:0] exp,
                       input string what);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 check(what, regRdata, exp);
  endtask

  // Counters are held through the edge that samples them
  task automatic step(input logic [11:0] l, input logic [11:0] p,
                      input logic exp);
    @(posedge clock);
    lineCnt <= l;
    pixCnt  <= p;
    @(posedge clock);
    #1 check("vblank", {31'h0, vblank}, {31'h0, exp});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and watchdog
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial begin
    nrst     = 1'b0;
    regAddr  = 4'h0;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead  = 1'b0;
    lineCnt  = 12'h100;
    pixCnt   = 12'h100;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      regRd(a[3:0], 32'h0, "pos reset");
    end
    check("mode", {29'h0, videoMode}, {29'h0, DVBW_RAW});
    regWr(ADDR_F1_END, 32'hffff_ffff);
    regRd(ADDR_F1_END, 32'h0fff_0fff, "f1 end");
    regWr(ADDR_F2_START, 32'hf5a5_f3c3);
    regRd(ADDR_F2_START, 32'h05a5_03c3, "f2 start");
    regRd(4'hf, 32'h0, "unmapped");
    regWr(ADDR_F1_START, 32'h0002_0003);
    regWr(ADDR_F1_END, 32'h0004_0005);
    regWr(ADDR_F2_START, 32'h0006_0007);
    regWr(ADDR_F2_END, 32'h0008_0009);
    regWr(ADDR_VBIT, 32'h1);
    foreach (modes[i]) begin
      regWr(ADDR_MODE, {29'h0, modes[i]});
      step(12'h002, 12'h004, 1'b0);
      step(12'h002, 12'h003, 1'b1);
      step(12'h100, 12'h100, 1'b1);
      step(12'h004, 12'h003, 1'b1);
      step(12'h004, 12'h005, 1'b0);
      step(12'h006, 12'h007, 1'b1);
      check("vbits", {30'h0, f2Vbit, f1Vbit}, 32'h1);
      step(12'h008, 12'h009, 1'b0);
      check("mode", {29'h0, videoMode}, {29'h0, modes[i]});
    end
    // Illegal mode code falls back to raw
    regWr(ADDR_MODE, 32'h3);
    regRd(ADDR_MODE, 32'h1, "mode fallback");
    // V bits follow their own register, not blanking
    regWr(ADDR_VBIT, 32'h2);
    step(12'h100, 12'h100, 1'b0);
    check("vbits", {30'h0, f2Vbit, f1Vbit}, 32'h2);
    regRd(ADDR_VBIT, 32'h2, "vbit reg");
    // Set and clear on one position: set wins
    regWr(ADDR_F2_END, 32'h0006_0007);
    step(12'h006, 12'h007, 1'b1);
    regRd(ADDR_STATUS, 32'h1, "status");
    check("rises", {24'h0, riseCount}, 32'h7);
    // Reset in mid-run clears positions and blanking
    @(posedge clock);
    nrst <= 1'b0;
    @(posedge clock);
    nrst <= 1'b1;
    regRd(ADDR_F2_START, 32'h0, "f2 start reset");
    check("vblank reset", {31'h0, vblank}, 32'h0);
    report_and_stop();
  end
endmodule
